/* rtl/mbc_coil_handler.sv */
// Purpose: Slave handler for single-coil write queries
// Assumes: rx bytes and rx_gap come from a same-clock UART; status from the motion core
// Notes: Half duplex; bytes arriving while a reply is sent are dropped
`timescale 1ns/100ps
`default_nettype none
`include "mbc_defs.svh"
module mbc_coil_handler
  import mbc_pkg::*;
#(
  parameter int unsigned SERVO_DELAY_CYC = `MBC_SERVO_DELAY_US * `MBC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] axis_num,
  input wire mbc_byte_t rx,
  input wire logic rx_gap,
  input wire logic tx_ready,
  input wire mbc_status_t status,
  input wire logic alarm_cause,
  input wire logic [15:0] cmd_speed,
  input wire logic [15:0] safety_speed,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic speed_limit_select,
  output logic servo_power_request,
  output logic servo_energized,
  output logic alarm_active,
  output logic alarm_clear_request,
  output logic travel_cancel,
  output logic [15:0] limited_speed
);

  localparam logic [15:0] SERVO_LIM = 16'(SERVO_DELAY_CYC);

  function automatic logic is_known_coil(input logic [15:0] a);
    is_known_coil = (a == `MBC_COIL_SPEED) || (a == `MBC_COIL_SERVO) ||
                    (a == `MBC_COIL_ALARM);
  endfunction

  mbc_state_t state, next_state;
  logic [7:0] rx_buf [0:7];
  logic [7:0] next_rx_buf [0:7];
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [15:0] crc_rx, next_crc_rx, crc_rx_step;
  logic [15:0] crc_tx, next_crc_tx, crc_tx_step;
  logic [3:0] tx_idx, next_tx_idx, tx_len, next_tx_len;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  logic next_speed_limit_select, next_servo_power_request;
  logic alarm_clear_coil, next_alarm_clear_coil, next_alarm_clear_request;
  logic next_travel_cancel;

  logic [7:0] own_addr;
  logic addr_bcast, addr_match, frame_ok, coil_write, data_ok;
  logic [15:0] coil_addr, coil_val;
  logic [3:0] tx_nxt;

  assign own_addr = {4'h0, axis_num} + `MBC_ADDR_BASE; // R01
  assign addr_bcast = rx_buf[0] == `MBC_ADDR_BCAST; // R02
  assign addr_match = addr_bcast || (rx_buf[0] == own_addr); // R01
  assign frame_ok = (rx_cnt == `MBC_FRAME_LEN) && (crc_rx == 16'h0000) && addr_match; // R05 R18
  assign coil_addr = {rx_buf[2], rx_buf[3]};
  assign coil_val = {rx_buf[4], rx_buf[5]};
  assign data_ok = (coil_val == `MBC_DATA_ON) || (coil_val == `MBC_DATA_OFF);
  assign coil_write = frame_ok && (rx_buf[1] == `MBC_FUNC_WRITE_COIL) &&
                      is_known_coil(coil_addr) && data_ok; // R04
  assign tx_nxt = tx_idx + 4'h1;

  mbc_crc16 u_crc_rx (
    .crc_in(crc_rx),
    .byte_in(rx.data),
    .crc_out(crc_rx_step)
  );

  mbc_crc16 u_crc_tx (
    .crc_in(crc_tx),
    .byte_in(tx_data),
    .crc_out(crc_tx_step)
  );

  // Frame receive, decode, coil update and reply
  always_comb begin
    next_state = state;
    next_rx_buf = rx_buf;
    next_rx_cnt = rx_cnt;
    next_crc_rx = crc_rx;
    next_crc_tx = crc_tx;
    next_tx_idx = tx_idx;
    next_tx_len = tx_len;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_speed_limit_select = speed_limit_select;
    next_servo_power_request = servo_power_request;
    next_alarm_clear_coil = alarm_clear_coil;
    next_alarm_clear_request = 1'b0;
    next_travel_cancel = 1'b0;
    case (state)
      ST_RX: begin
        if (rx.valid) begin
          if (rx_cnt < `MBC_FRAME_LEN) begin
            next_rx_buf[rx_cnt[2:0]] = rx.data;
          end
          if (rx_cnt < `MBC_FRAME_OVER) begin
            next_rx_cnt = rx_cnt + 4'h1; // R05
          end
          next_crc_rx = crc_rx_step; // R06
        end else if (rx_gap && (rx_cnt != 4'h0)) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ST_RX;
        next_rx_cnt = 4'h0;
        next_crc_rx = `MBC_CRC_INIT;
        if (coil_write) begin
          // Broadcast takes the same path as an addressed write
          if (coil_addr == `MBC_COIL_SPEED) begin
            next_speed_limit_select = coil_val == `MBC_DATA_ON; // R07 R03
          end
          if (coil_addr == `MBC_COIL_SERVO) begin
            next_servo_power_request = coil_val == `MBC_DATA_ON; // R09
          end
          if (coil_addr == `MBC_COIL_ALARM) begin
            next_alarm_clear_coil = coil_val == `MBC_DATA_ON;
            next_alarm_clear_request = alarm_clear_coil && (coil_val == `MBC_DATA_OFF); // R14
            next_travel_cancel = alarm_clear_coil && (coil_val == `MBC_DATA_OFF) &&
                                 status.paused; // R16
          end
        end
        if (frame_ok && !addr_bcast) begin
          next_state = ST_TX;
          next_tx_idx = 4'h0;
          next_crc_tx = `MBC_CRC_INIT;
          next_tx_valid = 1'b1;
          next_tx_data = rx_buf[0];
          next_tx_len = `MBC_FRAME_LEN; // R12
          if (!coil_write) begin
            next_tx_len = `MBC_EXC_LEN; // R13
            next_rx_buf[1] = `MBC_FUNC_EXC;
            if (rx_buf[1] != `MBC_FUNC_WRITE_COIL) begin
              next_rx_buf[2] = `MBC_EXC_ILL_FUNC;
            end else if (!is_known_coil(coil_addr)) begin
              next_rx_buf[2] = `MBC_EXC_ILL_ADDR;
            end else begin
              next_rx_buf[2] = `MBC_EXC_ILL_DATA;
            end
          end
        end
      end
      ST_TX: begin
        if (tx_ready) begin
          if (tx_idx < `MBC_EXC_CRC_LO) begin
            next_crc_tx = crc_tx_step; // R06
          end
          next_tx_idx = tx_nxt;
          if (tx_nxt == tx_len) begin
            next_tx_valid = 1'b0;
            next_state = ST_RX;
          end else if ((tx_len == `MBC_EXC_LEN) && (tx_nxt == `MBC_EXC_CRC_LO)) begin
            next_tx_data = crc_tx_step[7:0];
          end else if ((tx_len == `MBC_EXC_LEN) && (tx_nxt == `MBC_EXC_CRC_HI)) begin
            next_tx_data = crc_tx[15:8];
          end else begin
            next_tx_data = rx_buf[tx_nxt[2:0]]; // R12
          end
        end
      end
      default: begin
        next_state = ST_RX;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_RX;
      rx_cnt <= 4'h0;
      crc_rx <= `MBC_CRC_INIT;
      crc_tx <= `MBC_CRC_INIT;
      tx_idx <= 4'h0;
      tx_len <= 4'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      speed_limit_select <= 1'b0;
      servo_power_request <= 1'b0;
      alarm_clear_coil <= 1'b0;
      alarm_clear_request <= 1'b0;
      travel_cancel <= 1'b0;
    end else begin
      state <= next_state;
      rx_cnt <= next_rx_cnt;
      crc_rx <= next_crc_rx;
      crc_tx <= next_crc_tx;
      tx_idx <= next_tx_idx;
      tx_len <= next_tx_len;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      speed_limit_select <= next_speed_limit_select;
      servo_power_request <= next_servo_power_request;
      alarm_clear_coil <= next_alarm_clear_coil;
      alarm_clear_request <= next_alarm_clear_request;
      travel_cancel <= next_travel_cancel;
    end
  end

  // Buffer holds no control state, so it is left out of reset
  generate
    for (genvar g = 0; g < 8; g++) begin : g_buf
      always_ff @(posedge clk) begin
        rx_buf[g] <= next_rx_buf[g];
      end
    end
  endgenerate

  // Servo interlock, alarm latch and speed cap
  logic servo_ok;
  logic [15:0] servo_cnt, next_servo_cnt;
  logic next_servo_energized, next_alarm_active;
  logic [15:0] next_limited_speed;
  logic cap_on;

  assign servo_ok = !status.emergency_stop_flag && !status.major_failure &&
                    status.enable_status && !status.auto_servo_off; // R11
  assign cap_on = speed_limit_select && status.hand_operation_mode;

  always_comb begin
    next_servo_cnt = 16'h0000;
    if (servo_power_request && servo_ok) begin
      next_servo_cnt = (servo_cnt == SERVO_LIM) ? servo_cnt : servo_cnt + 16'h0001; // R10
    end
    next_servo_energized = servo_power_request && servo_ok && (servo_cnt == SERVO_LIM); // R10 R11
    // Cause is sampled after the clear, so a live fault re-latches at once
    next_alarm_active = alarm_cause || (alarm_active && !alarm_clear_request); // R14 R15
    next_limited_speed = (cap_on && (cmd_speed > safety_speed)) ? safety_speed : cmd_speed; // R08
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      servo_cnt <= 16'h0000;
      servo_energized <= 1'b0;
      alarm_active <= 1'b0;
      limited_speed <= 16'h0000;
    end else begin
      servo_cnt <= next_servo_cnt;
      servo_energized <= next_servo_energized;
      alarm_active <= next_alarm_active;
      limited_speed <= next_limited_speed;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  speed_cap_a: assert property (cap_on && (cmd_speed > safety_speed) |=> // R08
    limited_speed == $past(safety_speed)) else $error("speed not capped");
  servo_interlock_a: assert property (servo_energized |-> // R11
    $past(servo_ok) && $past(servo_power_request)) else $error("servo on without grant");
  servo_delay_a: assert property ($rose(servo_energized) |-> // R10
    $past(servo_cnt) == SERVO_LIM) else $error("servo on before delay");
  bcast_silent_a: assert property ((state == ST_EXEC) && addr_bcast |=> // R02
    !tx_valid) else $error("reply to broadcast");
  bad_frame_a: assert property ((state == ST_EXEC) && !frame_ok |=> // R18
    !tx_valid && $stable(speed_limit_select) && $stable(servo_power_request))
    else $error("bad frame acted on");
  speed_coil_a: assert property ((state == ST_EXEC) && coil_write && // R07
    (coil_addr == `MBC_COIL_SPEED) |=> speed_limit_select == $past(coil_val[15]))
    else $error("speed coil not written");
  clear_edge_a: assert property (alarm_clear_request |-> // R14
    $past(alarm_clear_coil) && !alarm_clear_coil) else $error("clear without edge");
  alarm_relatch_a: assert property (alarm_cause |=> alarm_active) // R15
    else $error("alarm not raised again");
  cancel_gate_a: assert property (travel_cancel |-> alarm_clear_request) // R16
    else $error("travel cancel without reset");
  echo_byte_a: assert property (tx_valid && (tx_len == `MBC_FRAME_LEN) && tx_ready && // R12
    (tx_idx < 4'h7) |=> tx_data == $past(rx_buf[tx_nxt[2:0]]))
    else $error("echo byte differs");

endmodule // mbc_coil_handler
`default_nettype wire

/* rtl/mbc_crc16.sv */
// Purpose: One-byte step of the frame CRC-16
// Assumes: Reflected polynomial, LSB first
// Notes: Purely combinational; the caller holds the running value
`timescale 1ns/100ps
`default_nettype none
`include "mbc_defs.svh"
module mbc_crc16 (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);

  logic [15:0] acc;

  always_comb begin
    acc = crc_in ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      acc = acc[0] ? ((acc >> 1) ^ `MBC_CRC_POLY) : (acc >> 1); // R06
    end
    crc_out = acc;
  end

endmodule // mbc_crc16
`default_nettype wire

/* rtl/mbc_defs.svh */
// Purpose: Constants for the single-coil write handler
// Assumes: 25 MHz clock; bytes arrive already framed by a UART on the same clock
// Notes: Included by the handler and the CRC module
//
// Behaviour
// R01 - Answer only slave address equal to axis number plus one, 01h to 10h.
// R02 - Address 00h is broadcast; accept such coil writes, never reply.
// R03 - Broadcast coil write updates the coil exactly like an addressed one.
// R04 - Function code 05 writes one single coil at the start address.
// R05 - Query is exactly 8 bytes between silent intervals.
// R06 - Last two bytes are CRC-16 over the frame, checked here and generated.
// R07 - Coil 0401h: FF00h enables safety speed, 0000h disables it.
// R08 - Safety speed enabled in manual mode caps every movement speed at parameter 35.
// R09 - Coil 0403h: FF00h requests servo on, 0000h requests servo off.
// R10 - Servo energizes only after the servo-on delay has elapsed.
// R11 - Servo on needs emergency stop 0, major failure 0, enable 1, auto-off 0.
// R12 - Successful coil change is answered with a byte-exact echo of the query.
// R13 - Invalid data gets an exception response or no response.
// R14 - Coil 0407h clears alarms on a write FF00h followed by 0000h.
// R15 - An alarm whose cause persists is raised again after reset.
// R16 - Alarm reset while paused cancels the remaining travel.
// R17 - Host must follow each alarm reset FF00h with 0000h to the same coil.
// R18 - Frames with bad CRC or foreign address are dropped without action.
`ifndef MBC_DEFS_SVH
`define MBC_DEFS_SVH

`define MBC_ADDR_BCAST 8'h00
`define MBC_ADDR_BASE 8'h01
`define MBC_FUNC_WRITE_COIL 8'h05
`define MBC_FUNC_EXC 8'h85
`define MBC_EXC_ILL_FUNC 8'h01
`define MBC_EXC_ILL_ADDR 8'h02
`define MBC_EXC_ILL_DATA 8'h03
`define MBC_COIL_SPEED 16'h0401
`define MBC_COIL_SERVO 16'h0403
`define MBC_COIL_ALARM 16'h0407
`define MBC_DATA_ON 16'hff00
`define MBC_DATA_OFF 16'h0000
`define MBC_FRAME_LEN 4'h8
`define MBC_FRAME_OVER 4'h9
`define MBC_EXC_LEN 4'h5
`define MBC_EXC_CRC_LO 4'h3
`define MBC_EXC_CRC_HI 4'h4
`define MBC_CRC_INIT 16'hffff
`define MBC_CRC_POLY 16'ha001
`define MBC_CLK_MHZ 25
`define MBC_SERVO_DELAY_US 1000

`endif

/* rtl/mbc_pkg.sv */
// Purpose: Types shared by the coil handler
// Assumes: Constants come from mbc_defs.svh
// Notes: Status bits arrive from the motion core as one struct
package mbc_pkg;

  typedef struct packed {
    logic emergency_stop_flag;
    logic major_failure;
    logic enable_status;
    logic auto_servo_off;
    logic hand_operation_mode;
    logic paused;
  } mbc_status_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mbc_byte_t;

  typedef enum logic [1:0] {
    ST_RX,
    ST_EXEC,
    ST_TX
  } mbc_state_t;

endpackage

/* test/mbc_host_model.sv */
// Purpose: Host end of the serial link that feeds the coil handler
// Assumes: Bytes driven on falling edges, reply bytes taken on rising edges
// Notes: Idle data line shows the inverted last byte, so stale reads show up
`timescale 1ns/100ps
`default_nettype none
module mbc_host_model
  import mbc_pkg::*;
(
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var mbc_byte_t rx,
  output logic rx_gap,
  output logic tx_ready
);
  logic [7:0] fr[8];
  logic [7:0] rq[$];
  logic slow;
  logic take;
  int wcnt;

  function automatic logic [15:0] crc(input logic [7:0] b[8], input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Whole query, then one gap pulse; bad flips CRC bits on purpose
  task automatic send(input logic [7:0] a, f, input logic [15:0] ca, v, bad);
    logic [15:0] c;
    fr = '{a, f, ca[15:8], ca[7:0], v[15:8], v[7:0], 8'h00, 8'h00};
    c = crc(fr, 6) ^ bad;
    fr[6] = c[7:0];
    fr[7] = c[15:8];
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      rx <= '{1'b1, fr[i]};
    end
    @(negedge clk);
    rx <= '{1'b0, ~fr[7]};
    rx_gap <= 1'b1;
    @(negedge clk);
    rx_gap <= 1'b0;
  endtask

  initial begin
    rx = '0;
    rx_gap = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
  end

  // Ready is a one-cycle pulse; slow mode stalls each byte three cycles
  // Byte is logged as ready rises: it stands until the taking edge, avoiding a race
  always @(negedge clk) begin
    take = tx_valid && !tx_ready && (wcnt >= (slow ? 3 : 0));
    if (take) begin
      rq.push_back(tx_data);
    end
    wcnt <= (tx_valid && !tx_ready) ? wcnt + 1 : 0;
    tx_ready <= take;
  end
endmodule // mbc_host_model
`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench for the coil handler
// Assumes: Servo delay shortened to 8 cycles
// Notes: Each scenario is a task of its own
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import mbc_pkg::*;
;
  logic clk, rst_n, rx_gap, tx_ready, alarm_cause;
  logic [3:0] axis_num;
  mbc_byte_t rx;
  mbc_status_t st;
  logic tx_valid, sel, preq, sen, aact, creq, tcan;
  logic [7:0] tx_data;
  logic [15:0] lim, spd;
  int err_total, total_checks, clr_cnt, can_cnt;

  mbc_coil_handler #(.SERVO_DELAY_CYC(8)) dut (.clk(clk), .rst_n(rst_n),
    .axis_num(axis_num), .rx(rx), .rx_gap(rx_gap), .tx_ready(tx_ready), .status(st),
    .alarm_cause(alarm_cause), .cmd_speed(spd), .safety_speed(16'h0100),
    .tx_valid(tx_valid), .tx_data(tx_data), .speed_limit_select(sel),
    .servo_power_request(preq), .servo_energized(sen), .alarm_active(aact),
    .alarm_clear_request(creq), .travel_cancel(tcan), .limited_speed(lim));
  mbc_host_model host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx(rx),
    .rx_gap(rx_gap), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses are counted on the falling edge, away from the edge that launches them
  always @(negedge clk) begin
    clr_cnt <= clr_cnt + ((creq === 1'b1) ? 1 : 0);
    can_cnt <= can_cnt + ((tcan === 1'b1) ? 1 : 0);
  end

  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One query; n reply bytes expected (8 echo, 5 exception, 0 silent)
  task automatic xfer(input logic [7:0] a, f, input logic [15:0] ca, v, bad,
                      input int n, input logic [7:0] code);
    logic [7:0] e[8];
    logic [15:0] c;
    int k;
    host.rq.delete();
    host.send(a, f, ca, v, bad);
    e = host.fr;
    if (n == 5) begin
      e[1] = 8'h85;
      e[2] = code;
      c = host.crc(e, 3);
      e[3] = c[7:0];
      e[4] = c[15:8];
    end
    k = 0;
    while (host.rq.size() < n && k < 80) begin
      @(negedge clk);
      k++;
    end
    repeat (20) @(negedge clk);
    chk(host.rq.size(), n);
    for (int i = 0; i < n && i < host.rq.size(); i++) chk(host.rq[i], e[i]);
  endtask

  task automatic t_speed;
    st = 6'h0a;
    host.slow = 1'b1;
    xfer(8'h01, 8'h05, 16'h0401, 16'hff00, 16'h0000, 8, 8'h00);
    host.slow = 1'b0;
    chk({host.fr[6], host.fr[7]}, 16'hdcca);
    chk(sel, 1'b1);
    chk(lim, 16'h0100);
    spd = 16'h0080;
    repeat (3) @(negedge clk);
    chk(lim, 16'h0080);
    spd = 16'h0500;
    st = 6'h08;
    repeat (3) @(negedge clk);
    chk(lim, 16'h0500);
  endtask

  task automatic t_drop;
    xfer(8'h00, 8'h05, 16'h0401, 16'h0000, 16'h0000, 0, 8'h00);
    chk(sel, 1'b0);
    xfer(8'h02, 8'h05, 16'h0401, 16'hff00, 16'h0000, 0, 8'h00);
    chk(sel, 1'b0);
    xfer(8'h01, 8'h05, 16'h0401, 16'hff00, 16'h0001, 0, 8'h00);
    chk(sel, 1'b0);
    axis_num = 4'h4;
    xfer(8'h05, 8'h05, 16'h0401, 16'hff00, 16'h0000, 8, 8'h00);
    chk(sel, 1'b1);
    axis_num = 4'h0;
  endtask

  task automatic t_exc;
    xfer(8'h01, 8'h05, 16'h0401, 16'h1234, 16'h0000, 5, 8'h03);
    xfer(8'h01, 8'h05, 16'h0408, 16'hff00, 16'h0000, 5, 8'h02);
    xfer(8'h01, 8'h06, 16'h0401, 16'h0000, 16'h0000, 5, 8'h01);
    chk(sel, 1'b1);
  endtask

  task automatic t_servo;
    logic [5:0] bad[4] = '{6'h28, 6'h18, 6'h00, 6'h0c};
    st = 6'h28;
    xfer(8'h01, 8'h05, 16'h0403, 16'hff00, 16'h0000, 8, 8'h00);
    chk(preq, 1'b1);
    chk(sen, 1'b0);
    st = 6'h08;
    repeat (6) @(negedge clk);
    chk(sen, 1'b0);
    repeat (6) @(negedge clk);
    chk(sen, 1'b1);
    for (int i = 0; i < 4; i++) begin
      st = bad[i];
      repeat (3) @(negedge clk);
      chk(sen, 1'b0);
      st = 6'h08;
      repeat (12) @(negedge clk);
      chk(sen, 1'b1);
    end
    xfer(8'h01, 8'h05, 16'h0403, 16'h0000, 16'h0000, 8, 8'h00);
    chk({preq, sen}, 2'b00);
  endtask

  task automatic t_alarm;
    alarm_cause = 1'b1;
    st = 6'h09;
    @(negedge clk);
    alarm_cause = 1'b0;
    repeat (2) @(negedge clk);
    chk(aact, 1'b1);
    xfer(8'h01, 8'h05, 16'h0407, 16'hff00, 16'h0000, 8, 8'h00);
    chk(clr_cnt, 0);
    xfer(8'h01, 8'h05, 16'h0407, 16'h0000, 16'h0000, 8, 8'h00);
    chk(clr_cnt, 1);
    chk(can_cnt, 1);
    chk(aact, 1'b0);
    alarm_cause = 1'b1;
    st = 6'h08;
    xfer(8'h00, 8'h05, 16'h0407, 16'hff00, 16'h0000, 0, 8'h00);
    xfer(8'h01, 8'h05, 16'h0407, 16'h0000, 16'h0000, 8, 8'h00);
    chk(clr_cnt, 2);
    chk(can_cnt, 1);
    chk(aact, 1'b1);
    alarm_cause = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    axis_num = 4'h0;
    st = 6'h08;
    alarm_cause = 1'b0;
    spd = 16'h0500;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk({tx_valid, sel, preq, sen, aact, creq, tcan}, 7'h00);
    t_speed();
    t_drop();
    t_exc();
    t_servo();
    t_alarm();
    report_and_stop();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (10000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
